// *** shared/nvh_map.svh ***
/*
 * Timing constants and field positions for the host controller of the
 * nonvolatile clock RAM port. Assumes a 10 MHz system clock.
 */
`ifndef NVH_MAP_SVH
`define NVH_MAP_SVH

`define NVH_CLK_PERIOD_NS 100
// access times (ns), slow-supply figures so both grades are covered
`define NVH_ADDRESS_ACCESS_TIME_NS 120
`define NVH_SELECT_ACCESS_TIME_NS 120
`define NVH_DRIVE_ACCESS_TIME_NS 100
`define NVH_OUTPUT_HOLD_TIME_NS 5
`define NVH_RECOVERY_GAP_TIME_NS 10
`define NVH_DATA_SETUP_TIME_NS 80
`define NVH_DATA_HOLD_TIME_NS 0
`define NVH_STORE_FLOAT_TIME_NS 40
`define NVH_STROBE_WIDTH_NS 110
// least times round up to whole cycles, never below one
`define NVH_CYC_UP(ns) (((ns) + `NVH_CLK_PERIOD_NS - 1) / `NVH_CLK_PERIOD_NS)
`define NVH_CYC_MIN1(ns) ((`NVH_CYC_UP(ns) < 1) ? 1 : `NVH_CYC_UP(ns))
`define NVH_READ_CYC `NVH_CYC_MIN1(`NVH_ADDRESS_ACCESS_TIME_NS)
`define NVH_STROBE_CYC `NVH_CYC_MIN1(`NVH_STROBE_WIDTH_NS)
`define NVH_GAP_CYC `NVH_CYC_MIN1(`NVH_RECOVERY_GAP_TIME_NS)
`define NVH_FLOAT_CYC `NVH_CYC_MIN1(`NVH_STORE_FLOAT_TIME_NS)
`define NVH_HOLD_CYC `NVH_CYC_MIN1(`NVH_DATA_HOLD_TIME_NS)

`define NVH_ADDR_W 19
`define NVH_DAY_ADDR 19'h7FFFC
`define NVH_BATT_BIT 7
`define NVH_CNT_W 4

`endif

// *** shared/nvh_pkg.sv ***
/*
 * Types for the host controller of the clock RAM port.
 * Assumes nvh_map.svh is on the include path.
 */
`include "nvh_map.svh"

package nvh_pkg;
	typedef enum logic [2:0] {
		NVH_IDLE,
		NVH_RD_WAIT,
		NVH_WR_FLOAT,
		NVH_WR_STROBE,
		NVH_WR_HOLD,
		NVH_GAP
	} nvh_state_t;

	typedef struct packed {
		nvh_state_t st;
		logic [`NVH_CNT_W-1:0] cnt;
		logic [`NVH_ADDR_W-1:0] addr;
		logic [7:0] wdata;
		logic [7:0] rdata;
		logic sel_n;
		logic drv_n;
		logic str_n;
		logic dq_oe;
		logic busy;
		logic done;
		logic rej;
		logic batt_ok;
		logic batt_seen;
		logic pg_s1;
		logic pg_s2;
		logic [7:0] dq_s1;
		logic [7:0] dq_s2;
		logic pfr;
		logic unrel;
	} nvh_regs_t;
endpackage

// *** hdl/nvh_host.sv ***
/*
 * Host controller driving the byte-wide asynchronous port of a
 * nonvolatile clock RAM: one read or one write per request.
 * Assumes the device pins are wired outside, data pins resolved from
 * DQ_OE_O; power-good arrives asynchronously from the device side.
 */
`timescale 1ns/1ps

module nvh_host
	import nvh_pkg::*;
(
	input wire logic CLOCK_I,
	input wire logic NRST_I,
	input wire logic REQ_I,
	input wire logic WRITE_I,
	input wire logic [`NVH_ADDR_W-1:0] ADDR_I,
	input wire logic [7:0] WDATA_I,
	input wire logic POWER_GOOD_I,
	input wire logic [7:0] DQ_I,
	output logic [`NVH_ADDR_W-1:0] ADDR_O,
	output logic [7:0] DQ_O,
	output logic DQ_OE_O,
	output logic SELECT_N_O,
	output logic DRIVE_N_O,
	output logic STORE_N_O,
	output logic BUSY_O,
	output logic DONE_O,
	output logic REJECT_O,
	output logic [7:0] RDATA_O,
	output logic POWER_FAIL_RESET_O,
	output logic BATTERY_GOOD_FLAG_O,
	output logic BATTERY_UNRELIABLE_O
);

	localparam logic [`NVH_CNT_W-1:0] READ_CYC = `NVH_CNT_W'(`NVH_READ_CYC);
	localparam logic [`NVH_CNT_W-1:0] STROBE_CYC = `NVH_CNT_W'(`NVH_STROBE_CYC);
	localparam logic [`NVH_CNT_W-1:0] GAP_CYC = `NVH_CNT_W'(`NVH_GAP_CYC);
	localparam logic [`NVH_CNT_W-1:0] FLOAT_CYC = `NVH_CNT_W'(`NVH_FLOAT_CYC);
	localparam logic [`NVH_CNT_W-1:0] HOLD_CYC = `NVH_CNT_W'(`NVH_HOLD_CYC);

	nvh_regs_t r_q;
	nvh_regs_t r_d;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		r_d = r_q;
		// data pins pass two flops like power-good; costs two read cycles
		r_d.pg_s1 = POWER_GOOD_I;
		r_d.pg_s2 = r_q.pg_s1;
		r_d.dq_s1 = DQ_I;
		r_d.dq_s2 = r_q.dq_s1;
		r_d.done = 1'b0;
		r_d.rej = 1'b0;
		case (r_q.st)
			NVH_IDLE: begin
				r_d.sel_n = 1'b1;
				r_d.drv_n = 1'b1;
				r_d.str_n = 1'b1;
				r_d.dq_oe = 1'b0;
				if (REQ_I) begin
					if (!r_q.pg_s2) begin
						r_d.rej = 1'b1;
					end else begin
						r_d.addr = ADDR_I;
						r_d.wdata = WDATA_I;
						r_d.busy = 1'b1;
						r_d.cnt = '0;
						r_d.sel_n = 1'b0;
						if (WRITE_I) begin
							r_d.st = NVH_WR_FLOAT;
						end else begin
							r_d.drv_n = 1'b0;
							r_d.st = NVH_RD_WAIT;
						end
					end
				end
			end
			NVH_RD_WAIT: begin
				r_d.cnt = r_q.cnt + 1'b1;
				// two extra cycles cover the data synchroniser
				// wait longest access
				if (r_q.cnt + 1'b1 >= READ_CYC + 2'd2) begin
					r_d.rdata = r_q.dq_s2;
					if (r_q.addr == `NVH_DAY_ADDR) begin
						r_d.batt_ok = r_q.dq_s2[`NVH_BATT_BIT];
						r_d.batt_seen = 1'b1;
					end
					r_d.done = 1'b1;
					r_d.sel_n = 1'b1;
					r_d.drv_n = 1'b1;
					r_d.cnt = '0;
					r_d.st = NVH_GAP;
				end
			end
			NVH_WR_FLOAT: begin
				r_d.cnt = r_q.cnt + 1'b1;
				if (r_q.cnt + 1'b1 >= FLOAT_CYC) begin
					r_d.dq_oe = 1'b1;
					r_d.str_n = 1'b0;
					r_d.cnt = '0;
					r_d.st = NVH_WR_STROBE;
				end
			end
			NVH_WR_STROBE: begin
				r_d.cnt = r_q.cnt + 1'b1;
				if (r_q.cnt + 1'b1 >= STROBE_CYC) begin
					r_d.str_n = 1'b1;
					r_d.sel_n = 1'b1;
					r_d.cnt = '0;
					r_d.st = NVH_WR_HOLD;
				end
			end
			NVH_WR_HOLD: begin
				r_d.cnt = r_q.cnt + 1'b1;
				if (r_q.cnt + 1'b1 >= HOLD_CYC) begin
					r_d.dq_oe = 1'b0;
					r_d.done = 1'b1;
					r_d.cnt = '0;
					r_d.st = NVH_GAP;
				end
			end
			NVH_GAP: begin
				r_d.cnt = r_q.cnt + 1'b1;
				if (r_q.cnt + 1'b1 >= GAP_CYC) begin
					r_d.busy = 1'b0;
					r_d.cnt = '0;
					r_d.st = NVH_IDLE;
				end
			end
			default: begin
				r_d.st = NVH_IDLE;
			end
		endcase
		// reset mirror, registered for a clean pin
		r_d.pfr = !r_q.pg_s2;
		// unreliable while the last flag read was clear
		r_d.unrel = r_d.batt_seen & !r_d.batt_ok;
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge CLOCK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			r_q <= '{st: NVH_IDLE, cnt: '0, addr: '0, wdata: 8'h00, rdata: 8'h00,
				sel_n: 1'b1, drv_n: 1'b1, str_n: 1'b1, dq_oe: 1'b0, busy: 1'b0,
				done: 1'b0, rej: 1'b0, batt_ok: 1'b1, batt_seen: 1'b0,
				pg_s1: 1'b0, pg_s2: 1'b0, dq_s1: 8'h00, dq_s2: 8'h00,
				pfr: 1'b1, unrel: 1'b0};
		end else begin
			r_q <= r_d;
		end
	end

	assign ADDR_O = r_q.addr;
	assign DQ_O = r_q.wdata;
	assign DQ_OE_O = r_q.dq_oe;
	assign SELECT_N_O = r_q.sel_n;
	assign DRIVE_N_O = r_q.drv_n;
	assign STORE_N_O = r_q.str_n;
	assign BUSY_O = r_q.busy;
	assign DONE_O = r_q.done;
	assign REJECT_O = r_q.rej;
	assign RDATA_O = r_q.rdata;
	assign POWER_FAIL_RESET_O = r_q.pfr;
	assign BATTERY_GOOD_FLAG_O = r_q.batt_ok;
	assign BATTERY_UNRELIABLE_O = r_q.unrel;

	////////////////////////////////////////////////////////////////////////
	// own pins only; what the device does is judged by the bench model
	a_no_contention: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
		r_q.dq_oe |-> r_q.drv_n) else $error("host drives data with drive pin low");
	a_write_strobe_sel: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
		!r_q.str_n |-> !r_q.sel_n && r_q.dq_oe) else $error("strobe without select or data");
	a_float_before_drive: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
		$rose(r_q.dq_oe) |-> $past(r_q.st) == NVH_WR_FLOAT) else $error("data driven early");
	a_addr_stable: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
		(!r_q.sel_n && $past(!r_q.sel_n)) |-> $stable(r_q.addr)) else $error("address moved");
	a_reject_pgood: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
		(r_q.st == NVH_IDLE && !r_q.pg_s2) |=> r_q.sel_n) else $error("access at power fail");
	a_read_wait: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
		$fell(r_q.drv_n) |-> !r_q.done [*4]) else $error("read finished too soon");
	a_gap_after: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
		$rose(r_q.sel_n) |=> r_q.sel_n) else $error("recovery gap missing");
	a_read_mode: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
		!r_q.drv_n |-> !r_q.sel_n && r_q.str_n) else $error("bad read pin state");
	a_reset_out: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
		!r_q.pg_s2 |=> POWER_FAIL_RESET_O) else $error("reset not shown");
	a_strobe_width: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
		$fell(r_q.str_n) |-> !r_q.str_n [*2] ##1 r_q.str_n) else $error("strobe width wrong");
	a_data_hold: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
		$rose(r_q.str_n) |-> r_q.dq_oe && $stable(r_q.wdata)) else $error("data lost at write end");
	a_reject_idle: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
		r_q.rej |-> r_q.sel_n && r_q.str_n && !r_q.dq_oe && !r_q.busy)
		else $error("reject moved pins");

endmodule // nvh_host

// *** verification/nvh_dev_model.sv ***
/* Behavioural clock RAM device on the host pins.
 * Assumes the bench resolves the data lines from both enables. */
`timescale 1ns/1ps
module nvh_dev_model
	import nvh_pkg::*;
(
	input wire logic [`NVH_ADDR_W-1:0] addr_i,
	input wire logic [7:0] dq_i,
	input wire logic sel_n_i,
	input wire logic drv_n_i,
	input wire logic str_n_i,
	input wire logic power_good_i,
	input wire logic batt_ok_i,
	output logic [7:0] dq_o,
	output logic dq_en_o
);
	logic [7:0] mem [int];
	logic [7:0] val;
	logic rd;
	assign rd = !sel_n_i && !drv_n_i && str_n_i && power_good_i;
	assign #`NVH_STORE_FLOAT_TIME_NS dq_en_o = rd;
	always @* begin
		val = mem.exists(int'(addr_i)) ? mem[int'(addr_i)] : 8'h00;
		if (addr_i == `NVH_DAY_ADDR)
			val[`NVH_BATT_BIT] = batt_ok_i;
	end
	// wrong data until access time passes
	always @(val or rd) begin
		dq_o = ~val;
		dq_o <= #`NVH_ADDRESS_ACCESS_TIME_NS val;
	end
	// store when the first of select and strobe ends
	always @(posedge (sel_n_i | str_n_i)) begin
		if (power_good_i)
			mem[int'(addr_i)] = dq_i;
	end
endmodule // nvh_dev_model

// *** verification/nvh_host_tb_top.sv ***
/* Self-checking bench: host controller against the device model.
 * Assumes the package and map header are compiled first. */
`timescale 1ns/1ps
module nvh_host_tb_top;
	import nvh_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic req = 1'b0;
	logic wr = 1'b0;
	logic [`NVH_ADDR_W-1:0] addr = '0;
	logic [7:0] wdata = 8'h00;
	logic pg = 1'b1;
	logic batt = 1'b1;
	logic [`NVH_ADDR_W-1:0] a_o;
	logic [7:0] dq_o, dq_dev, rdata, bus;
	logic oe, sel_n, drv_n, str_n, busy, done, rej, pfr, bgf, unrel, dev_en;
	int n_fail = 0;
	int checked = 0;
	int k;
	logic s;
	int n_str, n_oe, n_drv, n_busy;
	always #50 clk = ~clk;
	// released lines toggle on every clock edge, twice a cycle, so stale data cannot pass
	assign bus = oe ? dq_o : dev_en ? dq_dev : {4{clk, ~clk}};
	nvh_host u_nvh_host (.CLOCK_I(clk), .NRST_I(nrst), .REQ_I(req), .WRITE_I(wr),
		.ADDR_I(addr), .WDATA_I(wdata), .POWER_GOOD_I(pg), .DQ_I(bus), .ADDR_O(a_o),
		.DQ_O(dq_o), .DQ_OE_O(oe), .SELECT_N_O(sel_n), .DRIVE_N_O(drv_n),
		.STORE_N_O(str_n), .BUSY_O(busy), .DONE_O(done), .REJECT_O(rej), .RDATA_O(rdata),
		.POWER_FAIL_RESET_O(pfr), .BATTERY_GOOD_FLAG_O(bgf), .BATTERY_UNRELIABLE_O(unrel));
	nvh_dev_model u_nvh_dev_model (.addr_i(a_o), .dq_i(bus), .sel_n_i(sel_n),
		.drv_n_i(drv_n), .str_n_i(str_n), .power_good_i(pg), .batt_ok_i(batt),
		.dq_o(dq_dev), .dq_en_o(dev_en));
	////////////////////////////////////////////////////////////////
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// k: cycles from take to answer, s: select seen low
	task automatic op(input logic w, input logic [18:0] a, input logic [7:0] d,
		output int k, output logic s);
		@(negedge clk);
		req = 1'b1;
		wr = w;
		addr = a;
		wdata = d;
		@(negedge clk);
		req = 1'b0;
		k = 0;
		s = 1'b0;
		n_str = 0;
		n_oe = 0;
		n_drv = 0;
		n_busy = 0;
		// pins tallied once per cycle from the one after the take edge
		while (done !== 1'b1 && rej !== 1'b1 && k < 20) begin
			if (sel_n === 1'b0)
				s = 1'b1;
			n_str += int'(str_n === 1'b0);
			n_oe += int'(oe === 1'b1);
			n_drv += int'(drv_n === 1'b0);
			n_busy += int'(busy === 1'b1);
			@(negedge clk);
			k++;
		end
		@(negedge clk);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_rw;
		op(1'b1, 19'h00001, 8'hA5, k, s);
		check("write cycles", k, 4);
		check("write select", s, 1'b1);
		check("strobe cycles", n_str, `NVH_STROBE_CYC);
		check("data drive cycles", n_oe, 3);
		check("drive pin in write", n_drv, 0);
		check("write busy cycles", n_busy, 4);
		check("write address", a_o, 19'h00001);
		check("write data", dq_o, 8'hA5);
		check("busy after write", busy, 1'b0);
		check("done one cycle", done, 1'b0);
		op(1'b1, 19'h7FFFF, 8'h3C, k, s);
		op(1'b0, 19'h00001, 8'h00, k, s);
		check("read cycles", k, 4);
		check("read select", s, 1'b1);
		check("read drive cycles", n_drv, 4);
		check("strobe in read", n_str, 0);
		check("data drive in read", n_oe, 0);
		check("read busy cycles", n_busy, 4);
		check("read low byte", rdata, 8'hA5);
		op(1'b0, 19'h7FFFF, 8'h00, k, s);
		check("read top byte", rdata, 8'h3C);
	endtask
	task automatic t_batt;
		check("flag at reset", bgf, 1'b1);
		op(1'b1, `NVH_DAY_ADDR, 8'h03, k, s);
		op(1'b0, `NVH_DAY_ADDR, 8'h00, k, s);
		check("day byte", rdata, 8'h83);
		batt = 1'b0;
		op(1'b0, `NVH_DAY_ADDR, 8'h00, k, s);
		check("flag low", bgf, 1'b0);
		check("unreliable", unrel, 1'b1);
		batt = 1'b1;
	endtask
	task automatic t_power;
		pg = 1'b0;
		repeat (4) @(negedge clk);
		check("fail reset on", pfr, 1'b1);
		op(1'b1, 19'h00001, 8'hFF, k, s);
		check("reject cycles", k, 0);
		check("no select", s, 1'b0);
		check("no strobe", n_str, 0);
		pg = 1'b1;
		repeat (4) @(negedge clk);
		check("fail reset off", pfr, 1'b0);
		op(1'b0, 19'h00001, 8'h00, k, s);
		check("byte kept", rdata, 8'hA5);
	endtask
	// reset cut in the middle of a read
	task automatic t_reset;
		@(negedge clk);
		req = 1'b1;
		wr = 1'b0;
		addr = 19'h00001;
		@(negedge clk);
		req = 1'b0;
		@(negedge clk);
		check("select before cut", sel_n, 1'b0);
		nrst = 1'b0;
		@(negedge clk);
		check("select in reset", sel_n, 1'b1);
		check("drive pin in reset", drv_n, 1'b1);
		check("busy in reset", busy, 1'b0);
		check("fail reset in reset", pfr, 1'b1);
		check("flag in reset", bgf, 1'b1);
		check("unreliable in reset", unrel, 1'b0);
		nrst = 1'b1;
		repeat (4) @(negedge clk);
		check("fail reset released", pfr, 1'b0);
		op(1'b0, 19'h00001, 8'h00, k, s);
		check("read after reset", k, 4);
		check("byte after reset", rdata, 8'hA5);
	endtask
	initial begin
		repeat (20) @(negedge clk);
		nrst = 1'b1;
		repeat (3) @(negedge clk);
		t_rw;
		t_batt;
		t_power;
		t_reset;
		results;
	end
	// about twenty times the expected run
	initial begin
		#200000;
		n_fail++;
		results;
	end
endmodule // nvh_host_tb_top
